// ==== hdl/pmrs_pkg.sv ====
// Package for the power mode and reset sequencer: register map, fields, timings, types
package pmrs_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] PMRS_OSC_CTRL_ADDR = 8'h00;
   localparam logic [7:0] PMRS_STATUS_ADDR   = 8'h04;
   localparam logic [7:0] PMRS_CONFIG_ADDR   = 8'h08;
   localparam logic [7:0] PMRS_CORE_ADDR     = 8'h0C;

   // Oscillator control fields
   localparam int PMRS_SEL_HI_BIT   = 0;
   localparam int PMRS_STOP_HI_BIT  = 1;
   localparam int PMRS_MODE_LO_BIT  = 2;
   // Status fields
   localparam int PMRS_PD_BIT       = 3;
   localparam int PMRS_TO_BIT       = 4;
   // Config fields
   localparam int PMRS_PWRUP_LO_BIT = 0;
   localparam int PMRS_START_HI_BIT = 2;
   // Core control fields (write pulses, except the timer0 enable bit, which is stored as a level)
   localparam int PMRS_SLEEP_BIT    = 0;
   localparam int PMRS_WDCLR_BIT    = 1;
   localparam int PMRS_IRQ_EN_BIT   = 2;
   localparam int PMRS_IRQ_DIS_BIT  = 3;
   localparam int PMRS_TIMER0_ENABLE_BIT     = 4;

   // ************************************************************
   // Encodings and reset values
   // ************************************************************
   localparam logic [1:0] PMRS_MODE_RUN     = 2'h0;
   localparam logic [1:0] PMRS_MODE_HALT    = 2'h1;
   localparam logic [1:0] PMRS_MODE_STANDBY = 2'h2;
   localparam logic [1:0] PMRS_PWRUP_RST    = 2'h0;
   localparam logic [1:0] PMRS_RESP_OKAY    = 2'h0;
   localparam logic [1:0] PMRS_RESP_SLVERR  = 2'h2;
   localparam logic [11:0] PMRS_IRQ_VECTOR  = 12'h008;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int PMRS_CLK_MHZ        = 250;
   localparam int PMRS_WAKE_SETTLE    = 16;
   localparam int PMRS_OST_CYCLES     = 16;
   localparam int PMRS_PWRUP_US_0     = 4500;
   localparam int PMRS_PWRUP_US_1     = 18000;
   localparam int PMRS_PWRUP_US_2     = 72000;
   localparam int PMRS_PWRUP_US_3     = 288000;
   localparam int PMRS_PWRUP_CYC_0    = PMRS_PWRUP_US_0 * PMRS_CLK_MHZ;
   localparam int PMRS_PWRUP_CYC_1    = PMRS_PWRUP_US_1 * PMRS_CLK_MHZ;
   localparam int PMRS_PWRUP_CYC_2    = PMRS_PWRUP_US_2 * PMRS_CLK_MHZ;
   localparam int PMRS_PWRUP_CYC_3    = PMRS_PWRUP_US_3 * PMRS_CLK_MHZ;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      PMRS_ST_RESET,
      PMRS_ST_PWRUP,
      PMRS_ST_OST,
      PMRS_ST_RUN,
      PMRS_ST_STANDBY,
      PMRS_ST_HALT,
      PMRS_ST_SETTLE
   } pmrs_state_t;

   // Wake and reset sources
   typedef struct packed {
      logic timer0_ovf;
      logic port_b_change;
      logic ext_irq;
   } pmrs_wake_t;

   typedef struct packed {
      logic power_on;
      logic low_voltage_reset_event;
      logic ext_reset_n;
      logic watchdog_timeout;
   } pmrs_rst_t;

   // Clock and execution controls toward the core
   typedef struct packed {
      logic high_osc_run;
      logic low_osc_run;
      logic sys_clk_high;
      logic exec_enable;
      logic timer0_run;
      logic periph_enable;
      logic core_reset;
      logic watchdog_clear;
      logic resume_pulse;
      logic resume_vector;
   } pmrs_ctrl_t;

endpackage : pmrs_pkg

// ==== hdl/pmrs_seq.sv ====
// Power mode and reset sequencer with an AXI4-Lite register slave
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module pmrs_seq
   import pmrs_pkg::*;
#(
   parameter int PWRUP_CYC_0 = PMRS_PWRUP_CYC_0,
   parameter int PWRUP_CYC_1 = PMRS_PWRUP_CYC_1,
   parameter int PWRUP_CYC_2 = PMRS_PWRUP_CYC_2,
   parameter int PWRUP_CYC_3 = PMRS_PWRUP_CYC_3
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire pmrs_wake_t  wake_in,
   input  wire pmrs_rst_t   rst_in,
   input  wire logic        startup_high_clk,
   input  wire logic [1:0]  pwrup_sel,
   output      pmrs_ctrl_t  ctrl_out,
   output      logic [1:0]  op_mode_field
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      pmrs_state_t st;
      logic [31:0] cnt;
      logic        high_clock_select;
      logic        high_osc_stop;
      logic [1:0]  mode;
      logic        timeout_flag_n;
      logic        power_down_flag_n;
      logic        irq_enabled;
      logic        timer0_enable;
      logic        wd_clear;
      logic        resume;
      logic        resume_vec;
      logic [1:0]  pwrup_q;
      logic        start_hi_q;
      logic        aw_held;
      logic [7:0]  aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pmrs_regs_t;

   pmrs_regs_t  s_q;
   pmrs_regs_t  s_d;
   pmrs_wake_t  wake_meta_q;
   pmrs_wake_t  wake_sync_q;
   pmrs_rst_t   rst_meta_q;
   pmrs_rst_t   rst_sync_q;
   logic [2:0]  cfg_meta_q;
   logic [2:0]  cfg_sync_q;

   // Power-up wait length for a configuration choice
   function automatic logic [31:0] pwrup_len(input logic [1:0] sel);
      logic [31:0] len;
      len = 32'(PWRUP_CYC_0);
      if (sel == 2'h1)
         len = 32'(PWRUP_CYC_1);
      else if (sel == 2'h2)
         len = 32'(PWRUP_CYC_2);
      else if (sel == 2'h3)
         len = 32'(PWRUP_CYC_3);
      return len;
   endfunction : pwrup_len

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   // Pins and detectors come from outside, so two stages each
   always_ff @(posedge aclk)
   begin
      wake_meta_q <= wake_in;
      wake_sync_q <= wake_meta_q;
      rst_meta_q  <= rst_in;
      rst_sync_q  <= rst_meta_q;
      cfg_meta_q  <= {startup_high_clk, pwrup_sel};
      cfg_sync_q  <= cfg_meta_q;
   end

   logic        rst_event;
   logic        in_halt;
   logic        aw_go;
   logic        ar_go;
   logic [31:0] wr_val;
   logic [31:0] rd_val;

   assign in_halt   = (s_q.st == PMRS_ST_HALT) || (s_q.st == PMRS_ST_SETTLE);
   // Any of the four reset events holds the sequencer in reset
   assign rst_event = rst_sync_q.power_on | rst_sync_q.low_voltage_reset_event
                    | ~rst_sync_q.ext_reset_n | rst_sync_q.watchdog_timeout;
   assign aw_go     = s_q.aw_held && s_q.w_held && !s_q.bvalid;
   assign ar_go     = s_axi_arvalid && !s_q.rvalid;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      s_d            = s_q;
      s_d.wd_clear   = 1'b0;
      s_d.resume     = 1'b0;
      wr_val         = s_q.w_data;
      rd_val         = 32'h0000_0000;

      // Write channels are taken independently, response after both
      if (s_axi_awvalid && !s_q.aw_held)
      begin
         s_d.aw_held = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_held)
      begin
         s_d.w_held = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready)
         s_d.bvalid = 1'b0;
      if (s_q.rvalid && s_axi_rready)
         s_d.rvalid = 1'b0;

      // Register write; only lane 0 carries fields
      if (aw_go)
      begin
         s_d.aw_held = 1'b0;
         s_d.w_held  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = PMRS_RESP_OKAY;
         if (s_q.aw_addr == PMRS_OSC_CTRL_ADDR)
         begin
            if (s_q.w_strb[0] && s_q.st == PMRS_ST_RUN)
            begin
               s_d.high_clock_select = wr_val[PMRS_SEL_HI_BIT];
               // Stop bit lands in the same write that enters halt
               s_d.high_osc_stop     = wr_val[PMRS_STOP_HI_BIT];
               s_d.mode              = wr_val[PMRS_MODE_LO_BIT +: 2];
               if (wr_val[PMRS_MODE_LO_BIT +: 2] == PMRS_MODE_STANDBY)
                  s_d.st = PMRS_ST_STANDBY;
               else if (wr_val[PMRS_MODE_LO_BIT +: 2] == PMRS_MODE_HALT)
                  s_d.st = PMRS_ST_HALT;
               else
                  s_d.mode = PMRS_MODE_RUN;
            end
         end
         else if (s_q.aw_addr == PMRS_CORE_ADDR)
         begin
            if (s_q.w_strb[0])
            begin
               if (wr_val[PMRS_IRQ_EN_BIT])
                  s_d.irq_enabled = 1'b1;
               if (wr_val[PMRS_IRQ_DIS_BIT])
                  s_d.irq_enabled = 1'b0;
               s_d.timer0_enable = wr_val[PMRS_TIMER0_ENABLE_BIT];
               if (wr_val[PMRS_WDCLR_BIT])
               begin
                  s_d.wd_clear          = 1'b1;
                  s_d.timeout_flag_n    = 1'b1;
                  s_d.power_down_flag_n = 1'b1;
               end
               if (wr_val[PMRS_SLEEP_BIT] && s_q.st == PMRS_ST_RUN)
               begin
                  s_d.st   = PMRS_ST_HALT;
                  s_d.mode = PMRS_MODE_HALT;
               end
            end
         end
         else if (s_q.aw_addr != PMRS_STATUS_ADDR && s_q.aw_addr != PMRS_CONFIG_ADDR)
            s_d.bresp = PMRS_RESP_SLVERR;
      end

      // Halt entry side effects
      if (s_q.st == PMRS_ST_RUN && s_d.st == PMRS_ST_HALT)
      begin
         s_d.power_down_flag_n = 1'b0;
         s_d.timeout_flag_n    = 1'b1;
         s_d.wd_clear          = 1'b1;
      end

      // Register read
      if (ar_go)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = PMRS_RESP_OKAY;
         if (s_axi_araddr == PMRS_OSC_CTRL_ADDR)
            rd_val = {28'h0, s_q.mode, s_q.high_osc_stop, s_q.high_clock_select};
         else if (s_axi_araddr == PMRS_STATUS_ADDR)
            rd_val = {27'h0, s_q.timeout_flag_n, s_q.power_down_flag_n, 3'h0};
         else if (s_axi_araddr == PMRS_CONFIG_ADDR)
            rd_val = {29'h0, s_q.start_hi_q, s_q.pwrup_q};
         else if (s_axi_araddr == PMRS_CORE_ADDR)
            rd_val = {27'h0, s_q.timer0_enable, 1'b0, s_q.irq_enabled, 2'h0};
         else
            s_d.rresp = PMRS_RESP_SLVERR;
         s_d.rdata = rd_val;
      end

      // Mode sequencing
      case (s_q.st)
         PMRS_ST_RESET:
         begin
            // Straps caught once the reset event has gone away
            if (!rst_event)
            begin
               s_d.pwrup_q    = cfg_sync_q[1:0];
               s_d.start_hi_q = cfg_sync_q[2];
               s_d.cnt        = pwrup_len(cfg_sync_q[1:0]) - 32'h1;
               s_d.st         = PMRS_ST_PWRUP;
            end
         end
         PMRS_ST_PWRUP:
         begin
            if (s_q.cnt == 32'h0)
            begin
               s_d.cnt = 32'(PMRS_OST_CYCLES - 1);
               s_d.st  = PMRS_ST_OST;
            end
            else
               s_d.cnt = s_q.cnt - 32'h1;
         end
         PMRS_ST_OST:
         begin
            if (s_q.cnt == 32'h0)
            begin
               s_d.st                = PMRS_ST_RUN;
               s_d.high_clock_select = s_q.start_hi_q;
            end
            else
               s_d.cnt = s_q.cnt - 32'h1;
         end
         PMRS_ST_STANDBY:
         begin
            // Clock kept running, so no settling wait
            if (wake_sync_q.timer0_ovf || wake_sync_q.port_b_change || wake_sync_q.ext_irq)
            begin
               s_d.st         = PMRS_ST_RUN;
               s_d.mode       = PMRS_MODE_RUN;
               s_d.resume     = 1'b1;
               s_d.resume_vec = s_q.irq_enabled;
            end
         end
         PMRS_ST_HALT:
         begin
            // Timer0 is stopped here and cannot wake the core
            if (wake_sync_q.port_b_change || wake_sync_q.ext_irq)
            begin
               s_d.cnt = 32'(PMRS_WAKE_SETTLE - 1);
               s_d.st  = PMRS_ST_SETTLE;
            end
         end
         PMRS_ST_SETTLE:
         begin
            if (s_q.cnt == 32'h0)
            begin
               s_d.st         = PMRS_ST_RUN;
               s_d.mode       = PMRS_MODE_RUN;
               s_d.resume     = 1'b1;
               s_d.resume_vec = s_q.irq_enabled;
            end
            else
               s_d.cnt = s_q.cnt - 32'h1;
         end
         default:
         begin
         end
      endcase

      // Reset event overrides all; flags per cause, config kept
      if (rst_event && s_q.st != PMRS_ST_RESET)
      begin
         s_d.st                = PMRS_ST_RESET;
         s_d.mode              = PMRS_MODE_RUN;
         s_d.high_osc_stop     = 1'b0;
         s_d.irq_enabled       = 1'b0;
         s_d.timer0_enable     = 1'b0;
         if (rst_sync_q.power_on || rst_sync_q.low_voltage_reset_event)
         begin
            s_d.timeout_flag_n    = 1'b1;
            s_d.power_down_flag_n = 1'b1;
         end
         else if (rst_sync_q.watchdog_timeout)
         begin
            s_d.timeout_flag_n    = 1'b0;
            s_d.power_down_flag_n = !in_halt;
         end
         else if (in_halt)
         begin
            s_d.timeout_flag_n    = 1'b1;
            s_d.power_down_flag_n = 1'b1;
         end
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q                   <= '0;
         s_q.st                <= PMRS_ST_RESET;
         s_q.timeout_flag_n    <= 1'b1;
         s_q.power_down_flag_n <= 1'b1;
         s_q.high_clock_select <= 1'b1;
         s_q.pwrup_q           <= PMRS_PWRUP_RST;
         s_q.bresp             <= PMRS_RESP_OKAY;
         s_q.rresp             <= PMRS_RESP_OKAY;
      end
      else
         s_q <= s_d;
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Handshake readies combinational; data from flops
   assign s_axi_awready = !s_q.aw_held;
   assign s_axi_wready  = !s_q.w_held;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;
   assign op_mode_field = s_q.mode;

   // Clock and execution gating toward the core
   always_comb
   begin
      ctrl_out.sys_clk_high   = s_q.high_clock_select;
      // Stop honoured only in slow mode, standby does not stop it
      // Low oscillator restarts on wake, so the settle count has a clock
      ctrl_out.high_osc_run   = (s_q.st != PMRS_ST_HALT) && !(s_q.high_osc_stop && !s_q.high_clock_select);
      ctrl_out.low_osc_run    = (s_q.st != PMRS_ST_HALT);
      ctrl_out.exec_enable    = (s_q.st == PMRS_ST_RUN);
      ctrl_out.timer0_run     = s_q.timer0_enable && !in_halt && s_q.st != PMRS_ST_RESET;
      ctrl_out.periph_enable  = (s_q.st == PMRS_ST_RUN) || (s_q.st == PMRS_ST_STANDBY);
      ctrl_out.core_reset     = (s_q.st == PMRS_ST_RESET) || (s_q.st == PMRS_ST_PWRUP) || (s_q.st == PMRS_ST_OST);
      ctrl_out.watchdog_clear = s_q.wd_clear;
      ctrl_out.resume_pulse   = s_q.resume;
      ctrl_out.resume_vector  = s_q.resume_vec;
   end

endmodule : pmrs_seq

// ==== test/pmrs_seq_properties.sv ====
// Port-level checker for the power mode and reset sequencer
`timescale 1ns/1ps
module pmrs_seq_properties
   import pmrs_pkg::*;
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire pmrs_wake_t wake_in,
   input wire pmrs_rst_t  rst_in,
   input wire pmrs_ctrl_t ctrl_out,
   input wire logic [1:0] op_mode_field
);
   // ********
   // Mode decode
   // ********
   logic halt;
   logic stby;
   // Decoded once so the properties stay short
   assign halt = (op_mode_field == PMRS_MODE_HALT);
   assign stby = (op_mode_field == PMRS_MODE_STANDBY);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ********
   // Assertions
   // ********
   a_stby_no_exec:
      assert property (stby |-> !ctrl_out.exec_enable && ctrl_out.low_osc_run)
      else $error("core runs in standby");
   a_exec_in_run:
      assert property (ctrl_out.exec_enable |-> op_mode_field == PMRS_MODE_RUN)
      else $error("core runs outside run mode");
   a_halt_all_off:
      assert property ($rose(halt) |-> !ctrl_out.high_osc_run && !ctrl_out.low_osc_run
         && !ctrl_out.timer0_run && !ctrl_out.periph_enable)
      else $error("halt left something running");
   a_halt_wd_clear:
      assert property ($rose(halt) |-> ##[0:1] ctrl_out.watchdog_clear)
      else $error("watchdog not cleared on halt entry");
   // Two runs of eight give the sixteen quiet settle cycles
   a_halt_settle:
      assert property (halt && $rose(wake_in.ext_irq) |-> !ctrl_out.resume_pulse [*8] ##1
         !ctrl_out.resume_pulse [*8] ##[1:8] ctrl_out.resume_pulse)
      else $error("halt wake settle time wrong");
   a_stby_wake:
      assert property (stby && $rose(wake_in.timer0_ovf) |-> ##[1:5] ctrl_out.resume_pulse)
      else $error("standby wake missing or late");
   a_pin_reset:
      assert property ($fell(rst_in.ext_reset_n) |-> ##[1:4] ctrl_out.core_reset)
      else $error("pin reset not taken");
   a_wd_reset:
      assert property ($rose(rst_in.watchdog_timeout) |-> ##[1:4] ctrl_out.core_reset)
      else $error("watchdog reset not taken");
   a_hosc_slow_only:
      assert property (ctrl_out.exec_enable && !ctrl_out.high_osc_run |-> !ctrl_out.sys_clk_high)
      else $error("running on a stopped high clock");
   // Main scenarios reached
   c_stby_wake: cover property (stby ##1 ctrl_out.resume_pulse);
   c_halt: cover property ($rose(halt));
   c_reset: cover property ($rose(ctrl_out.core_reset));
endmodule : pmrs_seq_properties

bind pmrs_seq pmrs_seq_properties u_props (.aclk(aclk), .aresetn(aresetn), .wake_in(wake_in),
   .rst_in(rst_in), .ctrl_out(ctrl_out), .op_mode_field(op_mode_field));

// ==== test/tb_pmrs_seq.sv ====
// Self-checking bench for the power mode and reset sequencer
`timescale 1ns/1ps
module tb_pmrs_seq;
   import pmrs_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [31:0] s_axi_rdata;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, op_mode_field;
   logic        startup_high_clk = 1'b1;
   logic [1:0]  pwrup_sel = 2'h1;
   pmrs_wake_t  wake_in = '0;
   pmrs_rst_t   rst_in = 4'h2;
   pmrs_ctrl_t  ctrl_out;
   int          errors = 0;
   int          cmp_count = 0;

   // Short power-up counts keep the run brief
   pmrs_seq #(.PWRUP_CYC_0(20), .PWRUP_CYC_1(24), .PWRUP_CYC_2(28), .PWRUP_CYC_3(32)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .wake_in(wake_in), .rst_in(rst_in), .startup_high_clk(startup_high_clk),
      .pwrup_sel(pwrup_sel), .ctrl_out(ctrl_out), .op_mode_field(op_mode_field));

   initial forever #2 aclk = ~aclk;

   // ********
   // Bus and compare helpers
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR at %0t: got %08h expected %08h", $time, got, exp);
      end
   endtask : chk

   // Handshakes are judged at the negedge, where values are settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic da = 1'b0;
      logic dw = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(da && dw))
      begin
         @(negedge aclk);
         da = da || s_axi_awready;
         dw = dw || s_axi_wready;
         @(posedge aclk);
         if (da)
            s_axi_awvalid <= 1'b0;
         if (dw)
            s_axi_wvalid <= 1'b0;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp, er);
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata & m, ed);
      chk(s_axi_rresp, er);
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : rd

   // ********
   // Scenarios
   // ********
   task automatic t_powerup;
      int n = 0;
      do
      begin
         @(negedge aclk);
         n++;
      end
      while (ctrl_out.exec_enable !== 1'b1);
      chk(n >= 40 && n <= 44, 1'b1);
      chk(ctrl_out.sys_clk_high, 1'b1);
      rd(PMRS_STATUS_ADDR, 32'h18, 32'h18, PMRS_RESP_OKAY);
      rd(PMRS_CONFIG_ADDR, 32'h7, 32'h5, PMRS_RESP_OKAY);
   endtask : t_powerup

   task automatic t_clock;
      wr(PMRS_OSC_CTRL_ADDR, 32'h0, PMRS_RESP_OKAY);
      @(negedge aclk);
      chk({ctrl_out.sys_clk_high, ctrl_out.high_osc_run}, 2'h1);
      wr(PMRS_OSC_CTRL_ADDR, 32'h2, PMRS_RESP_OKAY);
      @(negedge aclk);
      chk({ctrl_out.sys_clk_high, ctrl_out.high_osc_run}, 2'h0);
      wr(PMRS_OSC_CTRL_ADDR, 32'h1, PMRS_RESP_OKAY);
      @(negedge aclk);
      chk({ctrl_out.sys_clk_high, ctrl_out.high_osc_run}, 2'h3);
   endtask : t_clock

   task automatic t_standby;
      int n = 0;
      wr(PMRS_CORE_ADDR, 32'h14, PMRS_RESP_OKAY);
      wr(PMRS_OSC_CTRL_ADDR, 32'h9, PMRS_RESP_OKAY);
      @(negedge aclk);
      chk({op_mode_field, ctrl_out.exec_enable, ctrl_out.timer0_run, ctrl_out.low_osc_run}, 5'h13);
      @(posedge aclk);
      wake_in.timer0_ovf <= 1'b1;
      do
      begin
         @(negedge aclk);
         n++;
      end
      while (ctrl_out.resume_pulse !== 1'b1);
      chk(n <= 5, 1'b1);
      chk({ctrl_out.resume_vector, ctrl_out.sys_clk_high}, 2'h3);
      @(posedge aclk);
      wake_in <= '0;
      @(negedge aclk);
      chk({op_mode_field, ctrl_out.exec_enable}, 3'h1);
      // Second standby, woken by a port change this time
      wr(PMRS_OSC_CTRL_ADDR, 32'h9, PMRS_RESP_OKAY);
      @(posedge aclk);
      wake_in.port_b_change <= 1'b1;
      repeat (4) @(negedge aclk);
      chk({op_mode_field, ctrl_out.exec_enable}, 3'h1);
      @(posedge aclk);
      wake_in <= '0;
   endtask : t_standby

   task automatic t_halt;
      int n = 0;
      wr(PMRS_CORE_ADDR, 32'h08, PMRS_RESP_OKAY);
      wr(PMRS_OSC_CTRL_ADDR, 32'h0, PMRS_RESP_OKAY);
      // Halt entry and oscillator stop in one write
      wr(PMRS_OSC_CTRL_ADDR, 32'h6, PMRS_RESP_OKAY);
      @(negedge aclk);
      chk({op_mode_field, ctrl_out.high_osc_run, ctrl_out.low_osc_run, ctrl_out.exec_enable,
           ctrl_out.timer0_run, ctrl_out.periph_enable}, 7'h20);
      rd(PMRS_STATUS_ADDR, 32'h18, 32'h10, PMRS_RESP_OKAY);
      @(posedge aclk);
      wake_in.timer0_ovf <= 1'b1;
      repeat (10) @(negedge aclk) chk(ctrl_out.resume_pulse, 1'b0);
      @(posedge aclk);
      wake_in <= 3'h1;
      do
      begin
         @(negedge aclk);
         n++;
      end
      while (ctrl_out.resume_pulse !== 1'b1);
      chk(n >= 17 && n <= 22, 1'b1);
      chk({ctrl_out.resume_vector, ctrl_out.sys_clk_high, ctrl_out.high_osc_run}, 3'h0);
      @(posedge aclk);
      wake_in <= '0;
      // Watchdog clear command brings both flags back to one
      wr(PMRS_CORE_ADDR, 32'h02, PMRS_RESP_OKAY);
      rd(PMRS_STATUS_ADDR, 32'h18, 32'h18, PMRS_RESP_OKAY);
   endtask : t_halt

   // Each entry: event, halt first, expected timeout and power-down flags
   task automatic t_resets;
      logic [4:0] tbl [8] = '{5'h01, 5'h09, 5'h04, 5'h0F, 5'h01, 5'h13, 5'h01, 5'h1B};
      logic [1:0] ev;
      wr(PMRS_OSC_CTRL_ADDR, 32'h0, PMRS_RESP_OKAY);
      for (int i = 0; i < 8; i++)
      begin
         ev = tbl[i][4:3];
         if (tbl[i][2])
            wr(PMRS_CORE_ADDR, 32'h01, PMRS_RESP_OKAY);
         @(posedge aclk);
         rst_in <= {ev == 2'h3, ev == 2'h2, ev != 2'h1, ev == 2'h0};
         if (i == 7)
         begin
            startup_high_clk <= 1'b0;
            pwrup_sel        <= 2'h2;
         end
         repeat (4) @(posedge aclk);
         @(negedge aclk);
         chk(ctrl_out.core_reset, 1'b1);
         @(posedge aclk);
         rst_in <= 4'h2;
         do @(negedge aclk); while (ctrl_out.exec_enable !== 1'b1);
         chk(ctrl_out.sys_clk_high, i != 7);
         rd(PMRS_STATUS_ADDR, 32'h18, {tbl[i][1:0], 3'h0}, PMRS_RESP_OKAY);
      end
      rd(PMRS_CONFIG_ADDR, 32'h7, 32'h2, PMRS_RESP_OKAY);
   endtask : t_resets

   task automatic t_bus;
      wr(8'h10, 32'h1, PMRS_RESP_SLVERR);
      rd(8'h10, 32'h0, 32'h0, PMRS_RESP_SLVERR);
      wr(PMRS_STATUS_ADDR, 32'h0, PMRS_RESP_OKAY);
      rd(PMRS_STATUS_ADDR, 32'h18, 32'h18, PMRS_RESP_OKAY);
   endtask : t_bus

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   // Whole run is well under two thousand cycles
   initial
   begin
      #40000;
      errors++;
      final_report();
   end

   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_powerup();
      t_clock();
      t_standby();
      t_halt();
      t_resets();
      t_bus();
      final_report();
   end
endmodule : tb_pmrs_seq
